/* File: seep_master.sv */
// Behavioural two-wire bus master that drives the slave under test.
module seep_master #(
    parameter int unsigned HALF = 20
) (
    // Bus: clock out, data released high by the pull-up
    output logic scl_clk,
    output logic sda_m,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_clk = 1'b1;
        sda_m = 1'b1;
    end
    // Reset needs link edges; data held high so no condition appears
    task automatic idle_pulses(input int n);
        repeat (n) begin
            #HALF scl_clk = 1'b0;
            #HALF scl_clk = 1'b1;
        end
    endtask
    task automatic start();
        if (!scl_clk) begin
            #10 sda_m = 1'b1;
            #(HALF - 10) scl_clk = 1'b1;
        end
        #HALF sda_m = 1'b0;
        #HALF scl_clk = 1'b0;
    endtask
    task automatic stop();
        #10 sda_m = 1'b0;
        #(HALF - 10) scl_clk = 1'b1;
        #HALF sda_m = 1'b1;
        #HALF;
    endtask
    // Data moves 10 ns after the fall so the slave has hold time
    task automatic bit_x(input logic b, output logic r);
        #10 sda_m = b;
        #(HALF - 10) scl_clk = 1'b1;
        #(HALF / 2) r = sda_line;
        #(HALF - HALF / 2) scl_clk = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack9,
                        output logic [7:0] q, output logic r9);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(ack9, r9);
    endtask
endmodule // seep_master

/* File: seep_slave.sv */
// Two-wire serial slave front end of a 16 x 8 nonvolatile memory.
//
// Functional notes
// [RQ1] Data falling while clock high is START; every command begins with it.
// [RQ2] Data rising while clock high is STOP; every operation ends with it.
// [RQ3] Data changes with clock high are only START or STOP events.
// [RQ4] One bit per clock pulse, taken as the data level in the high phase.
// [RQ5] Master starts only while both lines rest high.
// [RQ6] Ninth pulse per byte; the receiver holds data low to acknowledge.
// [RQ7] Acknowledge control byte only on code match and no write cycle.
// [RQ8] On master no-acknowledge after a read byte, release the data line.
// [RQ9] Control byte: 4-bit type code, three ignored bits, direction bit.
// [RQ10] Direction bit one selects read, zero selects write.
// [RQ11] Word address byte loads pointer from its low four bits only.
// [RQ12] Control, address, data each acknowledged; STOP launches write cycle.
// [RQ13] Self-timed write cycle lasts at most 4 ms, addressing ignored.
// [RQ14] Byte write leaves the pointer at the location just written.
// [RQ15] STOP before the write sequence completes aborts, nothing stored.
// [RQ16] More than eight data bits discard the buffered byte and refill.
// [RQ17] Several data bytes then STOP mid-byte aborts, nothing stored.
// [RQ18] Master polls completion by resending START and write control byte.
// [RQ19] Current read acknowledges and sends the byte at the pointer.
// [RQ20] Repeated START after word address ends write, keeps the pointer.
// [RQ21] Master acknowledge of a sent byte continues with the next address.
// [RQ22] Pointer increments as each read byte completes.
// [RQ23] Array of sixteen eight-bit locations addressed by the pointer.
// [RQ24] Pointer wraps from fifteen to zero.
// [RQ25] START or STOP mid-byte clears the bit count and restarts decoding.
module seep_slave
    import seep_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WC_CYCLES,
    parameter logic [3:0] DEV_CODE = DEV_CODE_DEF
) (
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial bus: clock from the master, open-drain data
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Status
    output logic write_busy
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: the bit is caught on the rising bus clock and handed
    // over with a toggle. The bit stays put until the next rising edge,
    // far longer than the core needs to see the toggle.

    logic lk_rst_n;
    seep_link_t lk_reg;
    seep_link_t lk_next;

    seep_sync u_lk_rst (
        .clk(scl_clk),
        .d(rst_n),
        .q(lk_rst_n)
    );

    always_comb begin
        lk_next = lk_reg;
        if (!lk_rst_n) begin
            lk_next = LINK_RST;
        end else begin
            lk_next.bit_v = sda_i; // [RQ4]
            lk_next.tgl = ~lk_reg.tgl;
        end
    end

    always_ff @(posedge scl_clk) begin
        lk_reg <= lk_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Crossing into the core clock

    logic [N_SYNC-1:0] raw_in;
    logic [N_SYNC-1:0] syn_out;
    logic scl_s;
    logic sda_s;
    logic tgl_s;

    assign raw_in = {scl_clk, sda_i, lk_reg.tgl};

    genvar gi;
    generate
        for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
            seep_sync u_sync (
                .clk(ref_clk),
                .d(raw_in[gi]),
                .q(syn_out[gi])
            );
        end
    endgenerate

    assign scl_s = syn_out[2];
    assign sda_s = syn_out[1];
    assign tgl_s = syn_out[0];

    ////////////////////////////////////////////////////////////////////////
    // Core events

    seep_core_t c_reg;
    seep_core_t c_next;
    logic start_ev;
    logic stop_ev;
    logic bit_ev;
    logic fall_ev;
    logic rx_bit;
    logic [DATA_W-1:0] byte_now;
    logic code_ok;

    // Both samples must show the clock high so that skew between the two
    // synchronisers around a clock edge is not taken for a condition
    assign start_ev = scl_s && c_reg.scl_d && c_reg.sda_d && !sda_s; // [RQ1] [RQ3]
    assign stop_ev = scl_s && c_reg.scl_d && !c_reg.sda_d && sda_s; // [RQ2] [RQ3]
    assign bit_ev = tgl_s != c_reg.tgl_d;
    assign fall_ev = c_reg.scl_d && !scl_s;
    assign rx_bit = lk_reg.bit_v;
    assign byte_now = {c_reg.shift[DATA_W-2:0], rx_bit};
    assign code_ok = byte_now[CODE_MSB:CODE_LSB] == DEV_CODE; // [RQ9]

    ////////////////////////////////////////////////////////////////////////
    // Core state machine

    always_comb begin
        c_next = c_reg;
        c_next.scl_d = scl_s;
        c_next.sda_d = sda_s;
        c_next.tgl_d = tgl_s;

        // Self-timed write cycle; addressing is refused meanwhile
        if (c_reg.busy) begin
            if (c_reg.wc_cnt == '0) begin
                c_next.busy = 1'b0; // [RQ13]
            end else begin
                c_next.wc_cnt = c_reg.wc_cnt - 1'b1;
            end
        end

        if (start_ev) begin
            // Repeated START drops buffered data but keeps the pointer
            c_next.state = ST_CTRL; // [RQ1] [RQ25]
            c_next.bit_cnt = '0; // [RQ25]
            c_next.wbuf_vld = 1'b0; // [RQ20]
            c_next.ack_pend = 1'b0;
            c_next.tx_on = 1'b0;
            c_next.sda_oe = 1'b0;
        end else if (stop_ev) begin
            // The STOP's own clock rise counts as one loose bit, so a
            // whole data byte followed by at most that bit is stored
            if (c_reg.state == ST_WDATA && c_reg.wbuf_vld &&
                c_reg.bit_cnt <= 4'h1) begin // [RQ12] [RQ15] [RQ17]
                c_next.mem[c_reg.ptr] = c_reg.wbuf; // [RQ23] [RQ14]
                c_next.busy = 1'b1; // [RQ12]
                c_next.wc_cnt = WC_W'(WRITE_CYCLES - 1); // [RQ13]
            end
            c_next.state = ST_IDLE; // [RQ2] [RQ25]
            c_next.bit_cnt = '0; // [RQ25]
            c_next.wbuf_vld = 1'b0;
            c_next.ack_pend = 1'b0;
            c_next.tx_on = 1'b0;
            c_next.sda_oe = 1'b0;
        end else begin
            if (bit_ev && c_reg.state != ST_IDLE &&
                c_reg.state != ST_IGNORE) begin
                if (c_reg.bit_cnt == BIT_ACK) begin
                    // Ninth pulse
                    c_next.bit_cnt = '0;
                    c_next.ack_pend = 1'b0;
                    if (c_reg.state == ST_READ) begin
                        if (!rx_bit) begin
                            c_next.tx = c_reg.mem[c_reg.ptr]; // [RQ19] [RQ21]
                            c_next.tx_on = 1'b1;
                        end else begin
                            c_next.tx_on = 1'b0; // [RQ8]
                            c_next.state = ST_IGNORE; // [RQ8]
                        end
                    end
                end else begin
                    c_next.shift = byte_now; // [RQ4]
                    c_next.bit_cnt = c_reg.bit_cnt + 1'b1;
                    // Dropped only at the second bit of a new byte: the
                    // first may be the clock rise that carries a STOP
                    if (c_reg.state == ST_WDATA && c_reg.bit_cnt == 4'h1) begin
                        c_next.wbuf_vld = 1'b0; // [RQ16]
                    end
                    if (c_reg.state == ST_READ && c_reg.tx_on) begin
                        c_next.tx = {c_reg.tx[DATA_W-2:0], 1'b1};
                    end
                    if (c_reg.bit_cnt == BIT_LAST) begin
                        case (c_reg.state)
                            ST_CTRL: begin
                                if (code_ok && !c_reg.busy) begin // [RQ7]
                                    c_next.ack_pend = 1'b1; // [RQ7]
                                    if (byte_now[RW_BIT]) begin
                                        c_next.state = ST_READ; // [RQ10]
                                    end else begin
                                        c_next.state = ST_WADDR; // [RQ10]
                                    end
                                end else begin
                                    c_next.state = ST_IGNORE; // [RQ7]
                                end
                            end
                            ST_WADDR: begin
                                c_next.ptr = byte_now[ADDR_W-1:0]; // [RQ11]
                                c_next.ack_pend = 1'b1; // [RQ12] [RQ20]
                                c_next.state = ST_WDATA;
                            end
                            ST_WDATA: begin
                                c_next.wbuf = byte_now; // [RQ16]
                                c_next.wbuf_vld = 1'b1;
                                c_next.ack_pend = 1'b1; // [RQ12]
                            end
                            ST_READ: begin
                                if (c_reg.tx_on) begin
                                    // Four-bit wrap from fifteen to zero
                                    c_next.ptr = c_reg.ptr + 1'b1; // [RQ22] [RQ24]
                                end
                            end
                            default: begin
                                c_next.state = c_reg.state;
                            end
                        endcase
                    end
                end
            end

            // Data only changes after the clock has gone low
            if (fall_ev) begin // [RQ3]
                if (c_next.state == ST_READ && c_next.tx_on &&
                    c_next.bit_cnt != BIT_ACK) begin
                    c_next.sda_oe = ~c_next.tx[DATA_W-1]; // [RQ19]
                end else begin
                    c_next.sda_oe = c_next.bit_cnt == BIT_ACK &&
                        c_next.ack_pend; // [RQ6] [RQ8]
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            c_reg <= CORE_RST;
        end else begin
            c_reg <= c_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Open drain: the pad only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe = c_reg.sda_oe;
    assign write_busy = c_reg.busy;

endmodule // seep_slave

/* File: seep_slave_props.sv */
// Port-level concurrent checks for the serial memory slave.
module seep_slave_props
    import seep_pkg::*;
#(
    parameter int unsigned WRITE_CYCLES = WC_CYCLES,
    parameter logic [3:0] DEV_CODE = DEV_CODE_DEF
) (
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial bus
    input wire logic scl_clk,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Status
    input wire logic write_busy
);
    ////////////////////////////////////////////////////////////////////////
    // Busy length counter; too long for a repetition operator
    logic [WC_W-1:0] busy_cnt_reg;
    logic [WC_W-1:0] busy_cnt_next;
    always_comb busy_cnt_next = write_busy ? busy_cnt_reg + 1'b1 : '0;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            busy_cnt_reg <= '0;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence start_seen;
        scl_clk && $past(scl_clk) && $fell(sda_i);
    endsequence
    sequence scl_high3;
        scl_clk [*3];
    endsequence
    sequence busy_launch;
        $rose(write_busy);
    endsequence
    sda_o_low_a: assert property (sda_o == 1'b0)
        else $error("data output value not low");
    oe_rise_low_a: assert property ($rose(sda_oe) |-> !$past(scl_clk))
        else $error("data pulled low while clock high");
    oe_hold_high_a: assert property (scl_high3 |-> $stable(sda_oe))
        else $error("data drive changed in clock high phase");
    busy_quiet_a: assert property (write_busy |-> !sda_oe)
        else $error("data driven during write cycle");
    busy_start_a: assert property (
        busy_launch |-> scl_clk && sda_i && !sda_oe)
        else $error("write cycle began without a stop");
    busy_min_a: assert property (busy_launch |-> write_busy [*8])
        else $error("write cycle dropped early");
    busy_len_a: assert property (
        $fell(write_busy) |-> busy_cnt_reg == WRITE_CYCLES)
        else $error("write cycle length wrong");
    start_release_a: assert property (
        start_seen |-> ##[0:3] !sda_oe)
        else $error("data still driven after start");
endmodule // seep_slave_props

bind seep_slave seep_slave_props #(
    .WRITE_CYCLES(WRITE_CYCLES),
    .DEV_CODE(DEV_CODE)
) u_props (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_clk(scl_clk),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .write_busy(write_busy)
);

/* File: seep_sync.sv */
// Package of constants and types, and a two-stage synchroniser.
package seep_pkg;
    // Clock rate and self-timed write cycle
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned T_WC_US = 4000;
    localparam int unsigned WC_CYCLES = T_WC_US * CLK_MHZ;
    localparam int unsigned WC_W = 20;
    // Array and byte layout
    localparam int unsigned MEM_DEPTH = 16;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CODE_MSB = 7;
    localparam int unsigned CODE_LSB = 4;
    localparam int unsigned RW_BIT = 0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // Device-type code default; the value is arbitrary
    localparam logic [3:0] DEV_CODE_DEF = 4'h5;
    // Number of signals synchronised into the core clock: two pins and the link toggle
    localparam int unsigned N_SYNC = 3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CTRL = 3'h1,
        ST_WADDR = 3'h3,
        ST_WDATA = 3'h2,
        ST_READ = 3'h6,
        ST_IGNORE = 3'h4
    } seep_state_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } seep_sync_t;

    typedef struct packed {
        logic bit_v;
        logic tgl;
    } seep_link_t;

    typedef struct packed {
        logic scl_d;
        logic sda_d;
        logic tgl_d;
        seep_state_t state;
        logic [3:0] bit_cnt;
        logic [DATA_W-1:0] shift;
        logic [DATA_W-1:0] tx;
        logic [DATA_W-1:0] wbuf;
        logic wbuf_vld;
        logic ack_pend;
        logic tx_on;
        logic [ADDR_W-1:0] ptr;
        logic busy;
        logic [WC_W-1:0] wc_cnt;
        logic sda_oe;
        logic [MEM_DEPTH-1:0][DATA_W-1:0] mem;
    } seep_core_t;

    localparam seep_link_t LINK_RST = '0;
    localparam seep_core_t CORE_RST = '0;
endpackage

////////////////////////////////////////////////////////////////////////////
module seep_sync
    import seep_pkg::*;
(
    // Clock
    input wire logic clk,
    // Asynchronous level in, synchronised level out
    input wire logic d,
    output logic q
);
    seep_sync_t s_reg;
    seep_sync_t s_next;

    // No reset here: the pair settles within two edges of its clock
    always_comb begin
        s_next.s1 = d;
        s_next.s2 = s_reg.s1;
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    assign q = s_reg.s2;
endmodule // seep_sync

/* File: tb_serial_eeprom_i2c_slave.sv */
// Self-checking bench for the serial memory slave front end.
module tb_serial_eeprom_i2c_slave
    import seep_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    err_total++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
    localparam int unsigned WCYC = 200;
    localparam logic [3:0] CODE = DEV_CODE_DEF;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl_clk, sda_m, sda_i, sda_o, sda_oe, write_busy;
    logic [7:0] exp_mem [16] = '{default: 8'h00};
    int err_total = 0;
    int samples_checked = 0;
    int seed = 32'h4829;
    assign sda_i = sda_m & ~(sda_oe & ~sda_o);
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    seep_slave #(.WRITE_CYCLES(WCYC), .DEV_CODE(CODE)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe(sda_oe), .write_busy(write_busy));
    seep_master #(.HALF(15)) mst (
        .scl_clk(scl_clk), .sda_m(sda_m), .sda_line(sda_i));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("mismatches %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // A write is stored only when it ends on a whole data byte
    function automatic logic stores(input int nb, input int nbit);
        return nb > 0 && nbit == 0;
    endfunction
    task automatic put(input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic r;
        mst.xfer(d, 1'b1, q, r);
        ok = ~r;
    endtask
    task automatic ctrl(input logic rw, input logic [3:0] c, output logic ok);
        mst.start();
        put({c, 3'($random(seed)), rw}, ok);
    endtask
    task automatic rd_cur(output logic [7:0] q);
        logic ok;
        logic r;
        ctrl(1'b1, CODE, ok);
        `CHK(ok, 1'b1)
        mst.xfer(8'hff, 1'b1, q, r);
        #20;
        `CHK(sda_oe, 1'b0)
        mst.stop();
    endtask
    task automatic set_ptr(input logic [3:0] ad);
        logic ok;
        ctrl(1'b0, CODE, ok);
        put({4'($random(seed)), ad}, ok);
    endtask
    // Polls stay bounded; a device that never answers ends the run
    task automatic poll(output int n);
        logic ok;
        n = 0;
        do begin
            ctrl(1'b0, CODE, ok);
            mst.stop();
            n++;
        end while (!ok && n < 20);
        if (!ok) begin
            err_total++;
            test_done();
        end
    endtask
    // Write sequence cut after nb data bytes plus nbit loose bits
    task automatic burst(input logic [3:0] ad, input int nb, input int nbit);
        logic ok;
        logic r;
        logic [7:0] d;
        set_ptr(ad);
        for (int i = 0; i < nb; i++) begin
            d = 8'($random(seed));
            put(d, ok);
            `CHK(ok, 1'b1)
        end
        repeat (nbit) mst.bit_x(1'b1, r);
        mst.stop();
        if (nb > 0 && nbit == 0) exp_mem[ad] = d;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int nbs [6] = '{1, 0, 0, 2, 2, 3};
        int nbits [6] = '{0, 0, 5, 0, 3, 0};
        logic [3:0] ad;
        logic [7:0] q;
        logic ok, r, keep;
        int n;
        mst.idle_pulses(4);
        repeat (8) @(negedge ref_clk);
        rst_n = 1'b1;
        // The link leaves reset only after two more bus clock rises
        mst.idle_pulses(3);
        repeat (4) @(negedge ref_clk);
        for (int i = 0; i < 12; i++) begin
            ad = 4'($random(seed));
            keep = stores(nbs[i % 6], nbits[i % 6]);
            burst(ad, nbs[i % 6], nbits[i % 6]);
            repeat (6) @(negedge ref_clk);
            `CHK(write_busy, keep)
            if (keep) begin
                poll(n);
                `CHK(n > 1, 1'b1)
                rd_cur(q);
                `CHK(q, exp_mem[ad])
            end else begin
                set_ptr(ad);
                rd_cur(q);
                `CHK(q, exp_mem[ad])
            end
        end
        for (int i = 0; i < 2; i++) begin
            ctrl(i[0], CODE ^ (4'h1 << i), ok);
            mst.stop();
            `CHK(ok, 1'b0)
        end
        set_ptr(4'he);
        ctrl(1'b1, CODE, ok);
        `CHK(ok, 1'b1)
        `CHK(write_busy, 1'b0)
        for (int k = 0; k < 4; k++) begin
            mst.xfer(8'hff, k == 3, q, r);
            `CHK(q, exp_mem[4'(14 + k)])
        end
        mst.stop();
        rd_cur(q);
        `CHK(q, exp_mem[4'h2])
        test_done();
    end
endmodule // tb_serial_eeprom_i2c_slave
